//--- design/dbp_data_pins.sv
// dbp_data_pins: shares data lines 0..7 with port F bits 9..15 and 0.
// assumes the memory core flags its active transfers and the port bank
// and control register contents arrive as plain levels on clk.
`timescale 1ns/10ps
module dbp_data_pins (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic mem_active,
	input wire logic mem_write,
	input wire logic [dbp_pkg::NUM_PINS-1:0] mem_wdata,
	output logic [dbp_pkg::NUM_PINS-1:0] mem_rdata,
	input wire logic idle_bus_drive_keep,
	input wire logic periph_we,
	input wire logic [dbp_pkg::PORTF_WIDTH-1:0] periph_wdata,
	input wire logic pullup_we,
	input wire logic [dbp_pkg::PORTF_WIDTH-1:0] pullup_wdata,
	input wire logic [dbp_pkg::PORTF_WIDTH-1:0] portf_dir,
	input wire logic [dbp_pkg::PORTF_WIDTH-1:0] portf_out,
	output logic [dbp_pkg::PORTF_WIDTH-1:0] portf_in,
	output logic [dbp_pkg::PORTF_WIDTH-1:0] portf_periph_sel,
	output logic [dbp_pkg::PORTF_WIDTH-1:0] portf_pullup_enable_reg,
	input wire logic [dbp_pkg::NUM_PINS-1:0] ext_data_in,
	output logic [dbp_pkg::NUM_PINS-1:0] ext_data_out,
	output logic [dbp_pkg::NUM_PINS-1:0] ext_data_oe,
	output logic [dbp_pkg::NUM_PINS-1:0] ext_data_pullup_en,
	output logic ctrl_drive_en
);
	import dbp_pkg::*;

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic logic [3:0] portf_bit(input int line);
		portf_bit = PORTF_BIT_OF_LINE[4*line +: 4];
	endfunction : portf_bit

	// ---------------------------------------------------------------
	// select and pull-up state
	// ---------------------------------------------------------------
	logic [PORTF_WIDTH-1:0] next_periph_sel;
	logic [PORTF_WIDTH-1:0] next_pullup;
	logic mem_drive;
	logic [NUM_PINS-1:0] sync_in;

	always_comb begin
		next_periph_sel = periph_we ? periph_wdata : portf_periph_sel;
		next_pullup = pullup_we ? pullup_wdata : portf_pullup_enable_reg;
		if (sys_rst) begin
			next_periph_sel = PORTF_PERIPH_RESET;
			next_pullup = PORTF_PULLUP_RESET;
		end
	end

	always_ff @(posedge clk) begin
		portf_periph_sel <= next_periph_sel;
		portf_pullup_enable_reg <= next_pullup;
	end

	// ---------------------------------------------------------------
	// bus drive: reads release the lines; idle follows drive-keep
	// ---------------------------------------------------------------
	// drive-keep resets low; software is expected to set it
	assign mem_drive = mem_active ? mem_write : idle_bus_drive_keep;
	assign ctrl_drive_en = mem_active | idle_bus_drive_keep;

	// ---------------------------------------------------------------
	// pins
	// ---------------------------------------------------------------
	for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
		dbp_pin_cell u_cell (
			.clk(clk),
			.sys_rst(sys_rst),
			.mem_sel(portf_periph_sel[portf_bit(i)]),
			.mem_drive(mem_drive),
			.mem_out(mem_wdata[i]),
			.gpio_dir_out(portf_dir[portf_bit(i)]),
			.gpio_out(portf_out[portf_bit(i)]),
			.pullup_en(portf_pullup_enable_reg[portf_bit(i)]),
			.pad_in(ext_data_in[i]),
			.pad_out(ext_data_out[i]),
			.pad_oe(ext_data_oe[i]),
			.pad_pullup_en(ext_data_pullup_en[i]),
			.pin_sync(sync_in[i])
		);
	end

	// unshared port bits 1..8 read zero here
	always_comb begin
		portf_in = '0;
		mem_rdata = sync_in;
		for (int i = 0; i < NUM_PINS; i++) begin
			portf_in[portf_bit(i)] = sync_in[i];
		end
	end

	a_reset_mem_sel: assert property (@(posedge clk) sys_rst |=> portf_periph_sel == PORTF_PERIPH_RESET)
		else $error("reset did not select memory function");
	a_reset_pullup: assert property (@(posedge clk) sys_rst |=> portf_pullup_enable_reg == PORTF_PULLUP_RESET)
		else $error("reset did not enable pull-ups");
	a_sel_hold: assert property (@(posedge clk) disable iff (sys_rst)
		!periph_we |=> portf_periph_sel == $past(portf_periph_sel))
		else $error("pin select changed without a write");
	a_idle_float: assert property (@(posedge clk) disable iff (sys_rst)
		!mem_active && !idle_bus_drive_keep && portf_periph_sel[9] |=> !ext_data_oe[0])
		else $error("idle bus driven with drive-keep clear");
	a_idle_keep: assert property (@(posedge clk) disable iff (sys_rst)
		!mem_active && idle_bus_drive_keep && portf_periph_sel[9] |=> ext_data_oe[0])
		else $error("idle bus released with drive-keep set");
	a_ctrl_idle: assert property (@(posedge clk) !mem_active && !idle_bus_drive_keep |-> !ctrl_drive_en)
		else $error("control outputs driven on idle bus");
	a_ctrl_active: assert property (@(posedge clk) mem_active |-> ctrl_drive_en)
		else $error("control outputs released during transfer");
	a_write_data: assert property (@(posedge clk) disable iff (sys_rst)
		mem_active && mem_write && portf_periph_sel[0] |=> ext_data_out[7] == $past(mem_wdata[7]))
		else $error("write data not on line 7");
	a_read_release: assert property (@(posedge clk) disable iff (sys_rst)
		mem_active && !mem_write && portf_periph_sel[0] |=> !ext_data_oe[7])
		else $error("line 7 driven during read");
	a_pullup_off: assert property (@(posedge clk) disable iff (sys_rst)
		portf_pullup_enable_reg[9] == 1'h0 |=> !ext_data_pullup_en[0])
		else $error("pull-up of line 0 not disabled");
	a_gpio_out: assert property (@(posedge clk) disable iff (sys_rst)
		!portf_periph_sel[15] && portf_dir[15] |=> ext_data_oe[6] && ext_data_out[6] == $past(portf_out[15]))
		else $error("port bit 15 output not driven");
endmodule : dbp_data_pins

//--- design/dbp_pkg.sv
// dbp_pkg: constants for the low data-bus pin sharing block.
// assumes one 100 MHz system clock and a synchronous active-high reset.
package dbp_pkg;
	// ---------------------------------------------------------------
	// pin map
	// ---------------------------------------------------------------
	localparam int NUM_PINS = 8;
	localparam int PORTF_WIDTH = 16;
	// port F bit number carried by each data line 0..7
	localparam logic [4*NUM_PINS-1:0] PORTF_BIT_OF_LINE = 32'h0FEDCBA9;
	// ---------------------------------------------------------------
	// reset values
	// ---------------------------------------------------------------
	localparam logic [PORTF_WIDTH-1:0] PORTF_PERIPH_RESET = 16'hFFFF;
	localparam logic [PORTF_WIDTH-1:0] PORTF_PULLUP_RESET = 16'hFFFF;
	localparam logic [PORTF_WIDTH-1:0] PORTF_DIR_RESET = 16'h0000;
	localparam logic DRIVE_KEEP_RESET = 1'h0;
	localparam logic DRIVE_KEEP_RECOMMENDED = 1'h1;
endpackage : dbp_pkg

//--- design/dbp_pin_cell.sv
// dbp_pin_cell: one shared data/port pin, output stage and input sync.
// assumes the pad resolves its level from out, oe and pull-up enable.
`timescale 1ns/10ps
module dbp_pin_cell (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic mem_sel,
	input wire logic mem_drive,
	input wire logic mem_out,
	input wire logic gpio_dir_out,
	input wire logic gpio_out,
	input wire logic pullup_en,
	input wire logic pad_in,
	output logic pad_out,
	output logic pad_oe,
	output logic pad_pullup_en,
	output logic pin_sync
);
	logic sync1;
	logic next_sync1;
	logic next_pin_sync;
	logic next_pad_out;
	logic next_pad_oe;
	logic next_pad_pullup_en;

	always_comb begin
		next_sync1 = pad_in;
		next_pin_sync = sync1;
		if (mem_sel) begin
			next_pad_out = mem_out;
			next_pad_oe = mem_drive;
		end else begin
			next_pad_out = gpio_out;
			next_pad_oe = gpio_dir_out;
		end
		next_pad_pullup_en = pullup_en;
		if (sys_rst) begin
			next_pad_oe = 1'h0;
			next_pad_pullup_en = 1'h1;
			next_pad_out = 1'h0;
		end
	end

	// outputs registered; reset handled above so drivers go off at the edge
	always_ff @(posedge clk) begin
		sync1 <= next_sync1;
		pin_sync <= next_pin_sync;
		pad_out <= next_pad_out;
		pad_oe <= next_pad_oe;
		pad_pullup_en <= next_pad_pullup_en;
	end

	a_reset_drv_off: assert property (@(posedge clk) sys_rst |=> !pad_oe && pad_pullup_en)
		else $error("pin driven or pull-up off after reset edge");
	a_gpio_dir: assert property (@(posedge clk) disable iff (sys_rst)
		!mem_sel && !gpio_dir_out |=> !pad_oe)
		else $error("input-mode port pin driven");
endmodule : dbp_pin_cell

//--- verif/dbp_ext_mem.sv
// dbp_ext_mem: external static memory on data lines 0..7.
// assumes the bench raises rd_drive only for read transfers.
`timescale 1ns/10ps
module dbp_ext_mem #(parameter logic [7:0] RD_WORD = 8'h3C) (
	input wire logic clk,
	input wire logic rd_drive,
	input wire logic [7:0] dev_out,
	input wire logic [7:0] dev_oe,
	input wire logic [7:0] dev_pu,
	output logic [7:0] pad
);
	logic [7:0] last = 8'h00;
	// a floating line without pull-up shows the inverse of its last driven level
	assign pad = (dev_oe & dev_out) | (~dev_oe & (rd_drive ? RD_WORD : (dev_pu | ~last)));
	always @(posedge clk) last <= (dev_oe & dev_out) | (~dev_oe & last);
endmodule : dbp_ext_mem

//--- verif/test_data_bus_port_pin_sharing.sv
// test_data_bus_port_pin_sharing: self-checking bench for dbp_data_pins.
// assumes dbp_ext_mem on the pads resolves their levels.
`timescale 1ns/10ps
module test_data_bus_port_pin_sharing;
	logic clk = 1'h0, sys_rst = 1'h1, mem_active = 1'h0, mem_write = 1'h0, idle_bus_drive_keep = 1'h0;
	logic we = 1'h0, ctrl_drive_en;
	logic [7:0] wdata = 8'hA5;
	logic [7:0] mem_rdata, ext_data_in, ext_data_out, ext_data_oe, ext_data_pullup_en;
	logic [15:0] portf_dir = 16'h0000, portf_in, portf_periph_sel, portf_pullup_enable_reg;
	int err_count = 0, n_compared = 0;
	always #5 clk = ~clk;
	dbp_data_pins dut_u (.clk, .sys_rst, .mem_active, .mem_write, .mem_wdata(wdata), .mem_rdata, .idle_bus_drive_keep,
		.periph_we(we), .periph_wdata(16'h0000), .pullup_we(we), .pullup_wdata(16'hFDFE), .portf_dir,
		.portf_out(16'h5500), .portf_in, .portf_periph_sel, .portf_pullup_enable_reg, .ext_data_in, .ext_data_out,
		.ext_data_oe, .ext_data_pullup_en, .ctrl_drive_en);
	dbp_ext_mem mem_u (.clk, .rd_drive(mem_active & ~mem_write), .dev_out(ext_data_out), .dev_oe(ext_data_oe),
		.dev_pu(ext_data_pullup_en), .pad(ext_data_in));
	task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		err_count += int'(seen !== exp);
		if (seen !== exp)
			$display("Error %s expected %h seen %h", nm, exp, seen);
	endtask : chk
	task st(input logic act, input logic wr, input logic keep, input logic [15:0] dir);
		@(posedge clk);
		mem_active <= act;
		mem_write <= wr;
		idle_bus_drive_keep <= keep;
		portf_dir <= dir;
		repeat (4) @(posedge clk);
	endtask : st
	task t_rst;
		repeat (11) @(posedge clk);
		chk("oe", ext_data_oe, 16'h0000);
		chk("pu", ext_data_pullup_en, 16'h00FF);
		chk("sel", portf_periph_sel, 16'hFFFF);
		@(posedge clk);
		sys_rst <= 1'h0;
	endtask : t_rst
	task t_mem;
		st(1'h1, 1'h1, 1'h0, 16'h0000);
		chk("oe", ext_data_oe, 16'h00FF);
		chk("out", ext_data_out, 16'h00A5);
		wdata <= 8'h5A;
		repeat (2) @(posedge clk);
		chk("out", ext_data_out, 16'h005A);
		st(1'h0, 1'h1, 1'h0, 16'h0000);
		chk("oe", ext_data_oe, 16'h0000);
		chk("ctl", ctrl_drive_en, 16'h0000);
		st(1'h0, 1'h1, 1'h1, 16'h0000);
		chk("oe", ext_data_oe, 16'h00FF);
		chk("ctl", ctrl_drive_en, 16'h0001);
		st(1'h1, 1'h0, 1'h1, 16'h0000);
		chk("rd", mem_rdata, 16'h003C);
	endtask : t_mem
	task t_port;
		@(posedge clk);
		we <= 1'h1;
		@(posedge clk);
		we <= 1'h0;
		st(1'h0, 1'h0, 1'h0, 16'hAA01);
		chk("oe", ext_data_oe, 16'h00D5);
		chk("in", portf_in, 16'h5400);
		chk("out", ext_data_out, 16'h002A);
		chk("sel", portf_periph_sel, 16'h0000);
		st(1'h0, 1'h0, 1'h0, 16'h5601);
		chk("oe", ext_data_oe, 16'h00AB);
		chk("in", portf_in, 16'hFC00);
		chk("pu", ext_data_pullup_en, 16'h007E);
		chk("pur", portf_pullup_enable_reg, 16'hFDFE);
	endtask : t_port
	task t_rerst;
		@(posedge clk);
		sys_rst <= 1'h1;
		repeat (3) @(posedge clk);
		chk("oe", ext_data_oe, 16'h0000);
		chk("pu", ext_data_pullup_en, 16'h00FF);
		chk("sel", portf_periph_sel, 16'hFFFF);
		chk("pur", portf_pullup_enable_reg, 16'hFFFF);
		@(posedge clk);
		sys_rst <= 1'h0;
		st(1'h0, 1'h0, 1'h0, 16'hFFFF);
		chk("oe", ext_data_oe, 16'h0000);
	endtask : t_rerst
	task test_done;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : test_done
	initial begin
		#20000;
		err_count++;
		test_done;
	end
	initial begin
		t_rst;
		t_mem;
		t_port;
		t_rerst;
		test_done;
	end
endmodule : test_data_bus_port_pin_sharing
